// ---- core/psp_pm_core.sv ----
// Power management core of a five-port switch with an APB register slave.
//
// Overview of operation
// - Downstream state local; port 0 governs switch.
// - D3hot lets the attached link enter L1.
// - Keep-context bit set retains state through D3hot.
// - L2/L3 Ready entry resets device unconditionally.
// - Reset gives D0 Uninitialized; configuration gives Active.
// - Power-state writes move D0 Active to D3hot, D3hot to D0 Uninitialized.
// - D3hot accepts type 0 config and self messages.
// - D3hot: other primary, all secondary requests UR.
// - D3hot reports TLP errors, drops others silently.
// - D3hot: own completions unexpected, transit completions routed.
// - Downstream ports send hot-plug PME from D3hot.
// - PME resent on retry time-out while flag set.
// - Uncleared PME at deep sleep raises wakeup.
// - Turn-off forwarded to active ports, acks collected.
// - All acks: ack upstream, upstream link L2/L3.
// - Upstream TLP during aggregation abandons it.
// - Abandoning TLP answered, forwarded, or held for retrain.
// - After abandon wait acks, retrain, forward held TLP.
// - Ack time-out counts as ack, link L2/L3.
// - Turn-off blocks PME until fundamental reset.
// - PME status flag sticky across fundamental reset.
`timescale 1ns/1ps
module psp_pm_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic aux_presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire psp_pkg::psp_tlp_t tlp_in,
  output psp_pkg::psp_verdict_t verdict,
  input wire logic err_valid,
  input wire logic err_from_tlp,
  input wire logic [2:0] err_port,
  output logic err_msg,
  input wire logic [psp_pkg::NDS-1:0] hp_event,
  output logic [psp_pkg::NDS-1:0] pme_tx,
  output logic [psp_pkg::NPORT-1:0] l1_allow,
  input wire logic us_turnoff_rx,
  input wire logic us_tlp_rx,
  input wire logic us_tlp_self,
  input wire logic [1:0] us_tlp_port,
  input wire logic [psp_pkg::NDS-1:0] ds_active,
  input wire logic [psp_pkg::NDS-1:0] ds_ack_rx,
  input wire logic [psp_pkg::NDS-1:0] ds_in_l0,
  output logic [psp_pkg::NDS-1:0] ds_turnoff_tx,
  output logic [psp_pkg::NDS-1:0] ds_l23_req,
  output logic [psp_pkg::NDS-1:0] ds_retrain,
  output logic us_ack_tx,
  output logic us_l23_ready,
  output logic tlp_local,
  output logic tlp_fwd,
  output logic [1:0] tlp_fwd_port,
  output logic wake_req
);
  import psp_pkg::*;

  function automatic logic in_d3(input logic [NPORT-1:0] v,
                                 input logic [2:0] p);
    in_d3 = v[0] | ((p < 3'(NPORT)) ? v[p] : 1'b0);
  endfunction

  function automatic logic pm_hit(input logic [11:0] a);
    pm_hit = (a[11:5] == 7'h00) && (a[4:2] < 3'(NPORT)) &&
             (a[1:0] == 2'h0);
  endfunction

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic wr_en, soft_rst, tick;
  logic [2:0] widx;
  logic [NPORT-1:0] d3v;
  logic [NDS-1:0] rt_start, rt_stop, rt_exp, at_start, at_exp;

  assign wr_en = psel & penable & pwrite;
  assign widx = paddr[4:2];

  // Microsecond tick shared by all timers.
  logic [7:0] tk_q, tk_d;
  always_comb begin
    tk_d = (tk_q == TICK_LAST) ? 8'h00 : tk_q + 8'h01;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tk_q <= 8'h00;
    end else begin
      tk_q <= tk_d;
    end
  end
  assign tick = (tk_q == TICK_LAST);

  // Configuration state, cleared by the device reset at L2/L3 entry.
  psp_dstate_t dst_q [NPORT];
  psp_dstate_t dst_d [NPORT];
  logic [NPORT-1:0] keep_q, keep_d;
  logic [15:0] retry_q, retry_d, ackto_q, ackto_d;

  always_comb begin
    retry_d = retry_q;
    ackto_d = ackto_q;
    keep_d = keep_q;
    for (int p = 0; p < NPORT; p++) begin
      dst_d[p] = dst_q[p];
      if (wr_en && pm_hit(paddr) && widx == 3'(p)) begin
        keep_d[p] = pwdata[F_KEEP];
        case (dst_q[p])
          DS_D0U: begin
            if (pwdata[F_CFG]) dst_d[p] = DS_D0A;
          end
          DS_D0A: begin
            if (pwdata[F_PS+1:F_PS] == PS_D3) dst_d[p] = DS_D3H;
          end
          DS_D3H: begin
            if (pwdata[F_PS+1:F_PS] == PS_D0) begin
              dst_d[p] = DS_D0U;
              // Without retained context the timer settings restart too.
              if (!keep_q[p]) begin
                retry_d = RETRY_RST;
                ackto_d = ACKTO_RST;
              end
            end
          end
          default: dst_d[p] = DS_D0U;
        endcase
      end
    end
    if (wr_en && paddr == A_RETRY) retry_d = pwdata[15:0];
    if (wr_en && paddr == A_ACKTO) ackto_d = pwdata[15:0];
    if (soft_rst) begin
      for (int p = 0; p < NPORT; p++) dst_d[p] = DS_D0U;
      keep_d = {NPORT{KEEP_RST}};
      retry_d = RETRY_RST;
      ackto_d = ACKTO_RST;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int p = 0; p < NPORT; p++) dst_q[p] <= DS_D0U;
      keep_q <= {NPORT{KEEP_RST}};
      retry_q <= RETRY_RST;
      ackto_q <= ACKTO_RST;
    end else begin
      for (int p = 0; p < NPORT; p++) dst_q[p] <= dst_d[p];
      keep_q <= keep_d;
      retry_q <= retry_d;
      ackto_q <= ackto_d;
    end
  end

  always_comb begin
    for (int p = 0; p < NPORT; p++) d3v[p] = (dst_q[p] == DS_D3H);
  end

  // Sticky PME status lives on the auxiliary reset only.
  logic [NDS-1:0] pme_status_flag_q, pme_status_flag_d;
  always_comb begin
    for (int i = 0; i < NDS; i++) begin
      pme_status_flag_d[i] = hp_event[i] | (pme_status_flag_q[i] & ~(wr_en && pm_hit(paddr) &&
                  widx == 3'(i + 1) && pwdata[F_PME_STATUS_FLAG]));
    end
  end
  always_ff @(posedge pclk or negedge aux_presetn) begin
    if (!aux_presetn) begin
      pme_status_flag_q <= '0;
    end else begin
      pme_status_flag_q <= pme_status_flag_d;
    end
  end

  // PME generation and retry.
  logic [NDS-1:0] arm_q, arm_d, pmetx_q, pmetx_d;
  logic block_q, block_d;
  always_comb begin
    for (int i = 0; i < NDS; i++) begin
      pmetx_d[i] = 1'b0;
      if (arm_q[i] && pme_status_flag_q[i] && !block_q && in_d3(d3v, 3'(i + 1)))
        pmetx_d[i] = 1'b1;
      if (rt_exp[i] && pme_status_flag_q[i] && !block_q)
        pmetx_d[i] = 1'b1;
      arm_d[i] = pme_status_flag_d[i] & (arm_q[i] | hp_event[i]) & ~pmetx_d[i];
      rt_start[i] = pmetx_d[i];
      rt_stop[i] = ~pme_status_flag_q[i];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_q <= '0;
      pmetx_q <= '0;
    end else begin
      arm_q <= arm_d;
      pmetx_q <= pmetx_d;
    end
  end

  // Turn-off fence: fan-out, ack aggregation, abandonment, retrain.
  psp_fence_t fen_q, fen_d;
  logic [NDS-1:0] acks_q, acks_d, dsto_q, dsto_d, retr_q, retr_d;
  logic usack_q, usack_d, local_q, local_d, fwd_q, fwd_d;
  logic held_q, held_d;
  logic [1:0] hport_q, hport_d, fwdp_q, fwdp_d;

  always_comb begin
    fen_d = fen_q;
    acks_d = acks_q;
    block_d = block_q;
    held_d = held_q;
    hport_d = hport_q;
    fwdp_d = fwdp_q;
    dsto_d = '0;
    retr_d = '0;
    usack_d = 1'b0;
    local_d = 1'b0;
    fwd_d = 1'b0;
    case (fen_q)
      FN_IDLE: begin
        if (us_turnoff_rx) begin
          dsto_d = ds_active;
          acks_d = ~ds_active;
          block_d = 1'b1;
          fen_d = FN_AGG;
        end
      end
      FN_AGG: begin
        acks_d = acks_q | ds_ack_rx | at_exp;
        if (us_tlp_rx) begin
          fen_d = FN_ABAND;
          if (us_tlp_self) begin
            local_d = 1'b1;
          end else if (ds_in_l0[us_tlp_port]) begin
            fwd_d = 1'b1;
            fwdp_d = us_tlp_port;
          end else begin
            held_d = 1'b1;
            hport_d = us_tlp_port;
          end
        end else if (&acks_q) begin
          usack_d = 1'b1;
          fen_d = FN_SENT;
        end
      end
      FN_ABAND: begin
        acks_d = acks_q | ds_ack_rx | at_exp;
        if (&acks_q) begin
          retr_d = '1;
          acks_d = '0;
          fen_d = FN_RETRAIN;
        end
      end
      FN_RETRAIN: begin
        if (!held_q) begin
          fen_d = FN_IDLE;
        end else if (ds_in_l0[hport_q]) begin
          fwd_d = 1'b1;
          fwdp_d = hport_q;
          held_d = 1'b0;
          fen_d = FN_IDLE;
        end
      end
      // Upstream TLPs arriving once the ack is scheduled are dropped.
      FN_SENT: fen_d = FN_SENT;
      default: fen_d = FN_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fen_q <= FN_IDLE;
      acks_q <= '0;
      block_q <= 1'b0;
      held_q <= 1'b0;
      hport_q <= 2'h0;
      fwdp_q <= 2'h0;
      dsto_q <= '0;
      retr_q <= '0;
      usack_q <= 1'b0;
      local_q <= 1'b0;
      fwd_q <= 1'b0;
    end else begin
      fen_q <= fen_d;
      acks_q <= acks_d;
      block_q <= block_d;
      held_q <= held_d;
      hport_q <= hport_d;
      fwdp_q <= fwdp_d;
      dsto_q <= dsto_d;
      retr_q <= retr_d;
      usack_q <= usack_d;
      local_q <= local_d;
      fwd_q <= fwd_d;
    end
  end

  assign soft_rst = usack_q;
  assign at_start = dsto_q;

  genvar g;
  generate
    for (g = 0; g < NDS; g++) begin : g_tmr
      psp_tmr u_retry (
        .pclk(pclk), .presetn(presetn), .tick(tick),
        .start(rt_start[g]), .stop(rt_stop[g]), .limit(retry_q),
        .expire(rt_exp[g]), .busy()
      );
      psp_tmr u_ackto (
        .pclk(pclk), .presetn(presetn), .tick(tick),
        .start(at_start[g]), .stop(ds_ack_rx[g]), .limit(ackto_q),
        .expire(at_exp[g]), .busy()
      );
    end
  endgenerate

  // TLP disposition, error filtering and link-level outputs.
  psp_verdict_t vd_q, vd_d;
  logic errm_q, errm_d, wake_q, wake_d;
  logic [NPORT-1:0] l1_q, l1_d;
  logic [NDS-1:0] l23_q, l23_d;
  always_comb begin
    vd_d = VD_NONE;
    if (tlp_in.valid && in_d3(d3v, tlp_in.port)) begin
      case (tlp_in.kind)
        TK_CFG0, TK_MSG_SELF: vd_d = tlp_in.sec ? VD_UR : VD_ACCEPT;
        TK_REQ: vd_d = VD_UR;
        TK_CPL_SELF: vd_d = VD_UC;
        default: vd_d = VD_ROUTE;
      endcase
    end else if (tlp_in.valid) begin
      case (tlp_in.kind)
        TK_REQ, TK_CPL_THRU: vd_d = VD_ROUTE;
        default: vd_d = VD_ACCEPT;
      endcase
    end
    errm_d = err_valid & (err_from_tlp | ~in_d3(d3v, err_port));
    for (int p = 0; p < NPORT; p++) l1_d[p] = in_d3(d3v, 3'(p));
    wake_d = (fen_q == FN_SENT) & (|pme_status_flag_q);
    l23_d = (fen_q == FN_IDLE || fen_q == FN_RETRAIN) ? '0 : acks_q;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vd_q <= VD_NONE;
      errm_q <= 1'b0;
      l1_q <= '0;
      wake_q <= 1'b0;
      l23_q <= '0;
    end else begin
      vd_q <= vd_d;
      errm_q <= errm_d;
      l1_q <= l1_d;
      wake_q <= wake_d;
      l23_q <= l23_d;
    end
  end

  // APB: read data is captured in the setup cycle, so no wait states.
  logic [31:0] rd_q, rd_d;
  logic serr_q, serr_d;
  always_comb begin
    rd_d = rd_q;
    serr_d = serr_q;
    if (psel && !penable) begin
      rd_d = 32'h00000000;
      serr_d = 1'b0;
      if (pm_hit(paddr)) begin
        rd_d[F_PS+1:F_PS] = d3v[widx] ? PS_D3 : PS_D0;
        rd_d[F_KEEP] = keep_q[widx];
        rd_d[F_DST+1:F_DST] = 2'(dst_q[widx]);
        rd_d[F_PME_STATUS_FLAG] = (widx != 3'h0) ? pme_status_flag_q[2'(widx - 3'h1)] : 1'b0;
      end else if (paddr == A_RETRY) begin
        rd_d[15:0] = retry_q;
      end else if (paddr == A_ACKTO) begin
        rd_d[15:0] = ackto_q;
      end else if (paddr == A_FENCE) begin
        rd_d[2:0] = 3'(fen_q);
        rd_d[F_ACKS+NDS-1:F_ACKS] = acks_q;
        rd_d[F_BLOCK] = block_q;
        rd_d[F_HELD] = held_q;
      end else begin
        serr_d = 1'b1;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_q <= 32'h00000000;
      serr_q <= 1'b0;
    end else begin
      rd_q <= rd_d;
      serr_q <= serr_d;
    end
  end

  assign prdata = rd_q;
  assign pready = 1'b1;
  assign pslverr = serr_q & psel & penable;
  assign verdict = vd_q;
  assign err_msg = errm_q;
  assign pme_tx = pmetx_q;
  assign l1_allow = l1_q;
  assign ds_turnoff_tx = dsto_q;
  assign ds_l23_req = l23_q;
  assign ds_retrain = retr_q;
  assign us_ack_tx = usack_q;
  assign us_l23_ready = (fen_q == FN_SENT);
  assign tlp_local = local_q;
  assign tlp_fwd = fwd_q;
  assign tlp_fwd_port = fwdp_q;
  assign wake_req = wake_q;

  sequence s_retry_due;
    rt_exp[0] && pme_status_flag_q[0] && !block_q;
  endsequence
  sequence s_agg_tlp;
    fen_q == FN_AGG && us_tlp_rx;
  endsequence

  property p_d3_entry;
    wr_en && paddr == 12'h004 && pwdata[1:0] == PS_D3 &&
    dst_q[1] == DS_D0A |=> dst_q[1] == DS_D3H ##1 l1_allow[1];
  endproperty
  a_d3_entry: assert property (p_d3_entry)
    else $error("D3hot entry did not reach L1 permission");
  property p_up_d3;
    dst_q[0] == DS_D3H |=> &l1_allow;
  endproperty
  a_up_d3: assert property (p_up_d3)
    else $error("Upstream D3hot did not cover all ports");
  property p_sec_ur;
    tlp_in.valid && tlp_in.sec && in_d3(d3v, tlp_in.port) &&
    tlp_in.kind inside {TK_CFG0, TK_MSG_SELF, TK_REQ} |=> verdict == VD_UR;
  endproperty
  a_sec_ur: assert property (p_sec_ur)
    else $error("Secondary request in D3hot not refused");
  property p_cpl_uc;
    tlp_in.valid && in_d3(d3v, tlp_in.port) &&
    tlp_in.kind == TK_CPL_SELF |=> verdict == VD_UC;
  endproperty
  a_cpl_uc: assert property (p_cpl_uc)
    else $error("Own completion in D3hot not unexpected");
  property p_err_drop;
    err_valid && !err_from_tlp && in_d3(d3v, err_port) |=> !err_msg;
  endproperty
  a_err_drop: assert property (p_err_drop)
    else $error("Non-TLP error reported in D3hot");
  property p_retry;
    s_retry_due |=> pme_tx[0];
  endproperty
  a_retry: assert property (p_retry)
    else $error("PME not resent after retry time-out");
  property p_block;
    block_q |=> pme_tx == '0;
  endproperty
  a_block: assert property (p_block)
    else $error("PME sent after turn-off");
  property p_fanout;
    fen_q == FN_IDLE && us_turnoff_rx |=>
      ds_turnoff_tx == $past(ds_active) && fen_q == FN_AGG;
  endproperty
  a_fanout: assert property (p_fanout)
    else $error("Turn-off not forwarded to active ports");
  property p_ack_up;
    fen_q == FN_AGG && &acks_q && !us_tlp_rx |=> us_ack_tx && us_l23_ready;
  endproperty
  a_ack_up: assert property (p_ack_up)
    else $error("Aggregated ack not sent upstream");
  property p_abandon;
    s_agg_tlp |=> fen_q == FN_ABAND && !us_ack_tx;
  endproperty
  a_abandon: assert property (p_abandon)
    else $error("Aggregation not abandoned on upstream TLP");
  property p_wake;
    fen_q == FN_SENT && |pme_status_flag_q |=> wake_req;
  endproperty
  a_wake: assert property (p_wake)
    else $error("Wakeup not raised for pending PME");
endmodule

// ---- core/psp_pkg.sv ----
// Shared constants and types for the switch power management block.
package psp_pkg;
  localparam int NDS = 4;
  localparam int NPORT = 5;
  localparam logic [11:0] A_PMCSR0 = 12'h000;
  localparam logic [11:0] A_RETRY = 12'h020;
  localparam logic [11:0] A_ACKTO = 12'h024;
  localparam logic [11:0] A_FENCE = 12'h028;
  localparam int F_PS = 0;
  localparam int F_KEEP = 3;
  localparam int F_CFG = 4;
  localparam int F_DST = 8;
  localparam int F_PME_STATUS_FLAG = 15;
  localparam int F_ACKS = 8;
  localparam int F_BLOCK = 16;
  localparam int F_HELD = 17;
  localparam logic [1:0] PS_D0 = 2'h0;
  localparam logic [1:0] PS_D3 = 2'h3;
  localparam logic KEEP_RST = 1'h1;
  localparam logic [15:0] RETRY_RST = 16'h0064;
  localparam logic [15:0] ACKTO_RST = 16'h0064;
  localparam int TICK_NS = 1000;
  localparam int CLK_NS = 5;
  localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] TICK_LAST = 8'(TICK_CYC - 1);

  typedef enum logic [1:0] {DS_D0U, DS_D0A, DS_D3H} psp_dstate_t;
  typedef enum logic [2:0] {
    FN_IDLE, FN_AGG, FN_SENT, FN_ABAND, FN_RETRAIN
  } psp_fence_t;
  typedef enum logic [2:0] {
    TK_CFG0, TK_MSG_SELF, TK_REQ, TK_CPL_SELF, TK_CPL_THRU
  } psp_kind_t;
  typedef enum logic [2:0] {
    VD_NONE, VD_ACCEPT, VD_UR, VD_UC, VD_ROUTE
  } psp_verdict_t;
  typedef struct packed {
    logic valid;
    logic sec;
    logic [2:0] port;
    psp_kind_t kind;
  } psp_tlp_t;
endpackage

// ---- core/psp_tmr.sv ----
// Tick-based time-out counter used for retry and acknowledge timers.
`timescale 1ns/1ps
module psp_tmr (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic start,
  input wire logic stop,
  input wire logic [15:0] limit,
  output logic expire,
  output logic busy
);
  logic [15:0] cnt_q, cnt_d;
  logic run_q, run_d;
  logic exp_q, exp_d;

  // Start wins over stop so a restart in the expiry cycle is never lost.
  always_comb begin
    cnt_d = cnt_q;
    run_d = run_q;
    exp_d = 1'b0;
    if (start) begin
      cnt_d = 16'h0000;
      run_d = 1'b1;
    end else if (stop) begin
      run_d = 1'b0;
    end else if (run_q && tick) begin
      if (({1'b0, cnt_q} + 17'h00001) >= {1'b0, limit}) begin
        exp_d = 1'b1;
        run_d = 1'b0;
      end else begin
        cnt_d = cnt_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 16'h0000;
      run_q <= 1'b0;
      exp_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      run_q <= run_d;
      exp_q <= exp_d;
    end
  end

  assign expire = exp_q;
  assign busy = run_q;
endmodule

// ---- tb/psp_link_partner.sv ----
// Behavioural model of the downstream link partners and their links.
`timescale 1ns/1ps
module psp_link_partner #(
  parameter int DLY = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [psp_pkg::NDS-1:0] act,
  input wire logic [psp_pkg::NDS-1:0] mute,
  input wire logic [psp_pkg::NDS-1:0] turnoff,
  input wire logic [psp_pkg::NDS-1:0] l23_req,
  input wire logic [psp_pkg::NDS-1:0] retrain,
  output logic [psp_pkg::NDS-1:0] ack,
  output logic [psp_pkg::NDS-1:0] in_l0
);
  import psp_pkg::*;
  int cnt [NDS];
  int rt;
  logic [NDS-1:0] down_q;
  logic [NDS-1:0] up_q;
  // Each port answers after a different delay; a muted port never answers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack <= '0;
      down_q <= '0;
      up_q <= '0;
      rt <= 0;
      for (int i = 0; i < NDS; i++) cnt[i] <= 0;
    end else begin
      rt <= (|retrain) ? 4 : ((rt > 0) ? rt - 1 : 0);
      for (int i = 0; i < NDS; i++) begin
        ack[i] <= (cnt[i] == 1);
        if (turnoff[i] && !mute[i]) cnt[i] <= DLY + 2 * i;
        else if (cnt[i] > 0) cnt[i] <= cnt[i] - 1;
        if (l23_req[i]) down_q[i] <= 1'b1;
        if (rt == 1) up_q[i] <= 1'b1;
      end
    end
  end
  // A retrained link comes up even if it was never active before.
  assign in_l0 = up_q | (act & ~down_q);
endmodule

// ---- tb/psp_pm_core_tb.sv ----
// Self-checking testbench of the switch power management core.
`timescale 1ns/1ps
module psp_pm_core_tb;
  import psp_pkg::*;
  logic pclk = 1'h0, presetn = 1'h0, aux_presetn = 1'h0;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err_msg, us_ack_tx, us_l23_ready, se;
  logic tlp_local, tlp_fwd, wake_req;
  logic err_valid = 1'h0, err_from_tlp = 1'h0, us_turnoff_rx = 1'h0;
  logic us_tlp_rx = 1'h0, us_tlp_self = 1'h0;
  logic [2:0] err_port = 3'h0;
  logic [1:0] us_tlp_port = 2'h0, tlp_fwd_port;
  logic [3:0] hp_event = 4'h0, ds_active = 4'h7, mute = 4'h0;
  logic [3:0] pme_tx, ds_ack_rx, ds_in_l0, ds_turnoff_tx;
  logic [3:0] ds_l23_req, ds_retrain;
  logic [4:0] l1_allow;
  psp_tlp_t tlp_in = '0;
  psp_verdict_t verdict;
  int failures = 0, tests_run = 0;

  initial forever #2.5 pclk = ~pclk;

  psp_pm_core u_dut (.pclk(pclk), .presetn(presetn),
    .aux_presetn(aux_presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tlp_in(tlp_in),
    .verdict(verdict), .err_valid(err_valid),
    .err_from_tlp(err_from_tlp), .err_port(err_port), .err_msg(err_msg),
    .hp_event(hp_event), .pme_tx(pme_tx), .l1_allow(l1_allow),
    .us_turnoff_rx(us_turnoff_rx), .us_tlp_rx(us_tlp_rx),
    .us_tlp_self(us_tlp_self), .us_tlp_port(us_tlp_port),
    .ds_active(ds_active), .ds_ack_rx(ds_ack_rx), .ds_in_l0(ds_in_l0),
    .ds_turnoff_tx(ds_turnoff_tx), .ds_l23_req(ds_l23_req),
    .ds_retrain(ds_retrain), .us_ack_tx(us_ack_tx),
    .us_l23_ready(us_l23_ready), .tlp_local(tlp_local),
    .tlp_fwd(tlp_fwd), .tlp_fwd_port(tlp_fwd_port), .wake_req(wake_req));

  psp_link_partner u_partner (.pclk(pclk), .presetn(presetn),
    .act(ds_active), .mute(mute), .turnoff(ds_turnoff_tx),
    .l23_req(ds_l23_req), .retrain(ds_retrain), .ack(ds_ack_rx),
    .in_l0(ds_in_l0));

  task automatic finish_test();
    if (failures == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // The master waits for pready without assuming a latency.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rd = prdata;
    se = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic dst(input int p, input logic [1:0] e);
    apb(1'h0, A_PMCSR0 + 12'(4 * p), 32'h0);
    chk("dev_state", {30'h0, e}, {30'h0, rd[F_DST+:2]});
  endtask

  task automatic tlp(input logic s, input logic [2:0] p, input psp_kind_t k,
                     input psp_verdict_t e);
    @(posedge pclk);
    tlp_in <= '{valid: 1'h1, sec: s, port: p, kind: k};
    @(posedge pclk);
    tlp_in <= '0;
    #1;
    chk("verdict", {29'h0, e}, {29'h0, verdict});
  endtask

  task automatic err(input logic f, input logic [2:0] p, input logic e);
    @(posedge pclk);
    err_valid <= 1'h1;
    err_from_tlp <= f;
    err_port <= p;
    @(posedge pclk);
    err_valid <= 1'h0;
    #1;
    chk("err_msg", {31'h0, e}, {31'h0, err_msg});
  endtask

  task automatic t_reset();
    apb(1'h0, A_PMCSR0, 32'h0);
    chk("keep", 32'h1, {31'h0, rd[F_KEEP]});
    chk("state0", 32'h0, {30'h0, rd[F_DST+:2]});
    apb(1'h0, A_RETRY, 32'h0);
    chk("retry_rst", {16'h0, RETRY_RST}, rd);
    apb(1'h0, 12'h030, 32'h0);
    chk("unmapped", 32'h1, {31'h0, se});
  endtask

  task automatic t_d3();
    apb(1'h1, 12'h004, 32'h0000_0010);
    dst(1, 2'h1);
    apb(1'h1, 12'h004, 32'h0000_0009);
    dst(1, 2'h1);
    apb(1'h1, 12'h004, 32'h0000_000B);
    dst(1, 2'h2);
    chk("l1_allow", 32'h2, {27'h0, l1_allow});
    tlp(1'h0, 3'h1, TK_CFG0, VD_ACCEPT);
    tlp(1'h0, 3'h1, TK_MSG_SELF, VD_ACCEPT);
    tlp(1'h0, 3'h1, TK_REQ, VD_UR);
    tlp(1'h1, 3'h1, TK_CFG0, VD_UR);
    tlp(1'h0, 3'h1, TK_CPL_SELF, VD_UC);
    tlp(1'h1, 3'h1, TK_CPL_THRU, VD_ROUTE);
    tlp(1'h0, 3'h2, TK_REQ, VD_ROUTE);
    tlp(1'h0, 3'h2, TK_CPL_SELF, VD_ACCEPT);
    err(1'h0, 3'h1, 1'h0);
    err(1'h1, 3'h1, 1'h1);
    err(1'h0, 3'h2, 1'h1);
    apb(1'h1, 12'h004, 32'h0000_0008);
    dst(1, 2'h0);
    apb(1'h1, 12'h004, 32'h0000_0010);
    apb(1'h1, 12'h004, 32'h0000_000B);
  endtask

  task automatic t_pme();
    int n;
    logic seen;
    apb(1'h1, A_RETRY, 32'h2);
    @(posedge pclk);
    hp_event <= 4'h1;
    @(posedge pclk);
    hp_event <= 4'h0;
    @(posedge pclk);
    #1;
    chk("pme_first", 32'h1, {28'h0, pme_tx});
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (pme_tx[0] !== 1'h1 && n < 450);
    chk("pme_retry", 32'h1, {31'h0, n >= 195 && n <= 405});
    apb(1'h1, 12'h004, 32'h0000_800B);
    seen = 1'h0;
    repeat (450) begin
      @(posedge pclk);
      #1;
      seen |= pme_tx[0];
    end
    chk("pme_stop", 32'h0, {31'h0, seen});
  endtask

  task automatic t_fence();
    int n;
    logic seen;
    apb(1'h1, A_ACKTO, 32'h1);
    @(posedge pclk);
    hp_event <= 4'h2;
    @(posedge pclk);
    hp_event <= 4'h0;
    apb(1'h1, A_PMCSR0, 32'h0000_0010);
    apb(1'h1, A_PMCSR0, 32'h0000_000B);
    mute <= 4'h4;
    @(posedge pclk);
    us_turnoff_rx <= 1'h1;
    @(posedge pclk);
    us_turnoff_rx <= 1'h0;
    hp_event <= 4'h8;
    #1;
    chk("turnoff", 32'h7, {28'h0, ds_turnoff_tx});
    @(posedge pclk);
    hp_event <= 4'h0;
    n = 0;
    seen = 1'h0;
    do begin
      @(posedge pclk);
      #1;
      n++;
      seen |= |pme_tx;
    end while (us_ack_tx !== 1'h1 && n < 600);
    chk("ack_up", 32'h1, {31'h0, us_ack_tx});
    chk("l23_up", 32'h1, {31'h0, us_l23_ready});
    chk("l23_ds", 32'h1, {31'h0, ds_l23_req[2]});
    chk("pme_block", 32'h0, {31'h0, seen});
    @(posedge pclk);
    @(posedge pclk);
    #1;
    chk("wake", 32'h1, {31'h0, wake_req});
    dst(1, 2'h0);
    mute <= 4'h0;
  endtask

  task automatic t_abandon();
    int n;
    logic acked;
    logic [3:0] rt;
    @(posedge pclk);
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, 12'h008, 32'h0);
    chk("sticky", 32'h1, {31'h0, rd[F_PME_STATUS_FLAG]});
    @(posedge pclk);
    us_turnoff_rx <= 1'h1;
    @(posedge pclk);
    us_turnoff_rx <= 1'h0;
    us_tlp_rx <= 1'h1;
    us_tlp_port <= 2'h3;
    @(posedge pclk);
    us_tlp_rx <= 1'h0;
    #1;
    chk("held", 32'h0, {30'h0, tlp_fwd, tlp_local});
    n = 0;
    acked = 1'h0;
    rt = 4'h0;
    do begin
      @(posedge pclk);
      #1;
      n++;
      acked |= us_ack_tx;
      if (ds_retrain !== 4'h0) rt = ds_retrain;
    end while (tlp_fwd !== 1'h1 && n < 300);
    chk("retrain", 32'hF, {28'h0, rt});
    chk("fwd", 32'h1, {31'h0, tlp_fwd});
    chk("fwd_port", 32'h3, {30'h0, tlp_fwd_port});
    chk("no_ack", 32'h0, {31'h0, acked});
    @(posedge pclk);
    us_turnoff_rx <= 1'h1;
    @(posedge pclk);
    us_turnoff_rx <= 1'h0;
    us_tlp_rx <= 1'h1;
    us_tlp_self <= 1'h1;
    @(posedge pclk);
    us_tlp_rx <= 1'h0;
    us_tlp_self <= 1'h0;
    #1;
    chk("local", 32'h1, {31'h0, tlp_local});
  endtask

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    aux_presetn <= 1'h1;
    t_reset();
    t_d3();
    t_pme();
    t_fence();
    t_abandon();
    finish_test();
  end

  // The whole run needs under two thousand cycles; this ceiling cuts a hang.
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    $display("ERROR run_time expected done seen hang");
    finish_test();
  end
endmodule
